//--- rtl/intc_pkg.sv
// shared constants and carrier types for the interrupt control block
package intc_pkg;

  // ------------------------------------------------------------------
  // register offsets on the plain register port
  // ------------------------------------------------------------------
  localparam logic [7:0] CENTRAL_CTRL_ADDR = 8'he6; // central_interrupt_control
  localparam logic [7:0] EDGE_SEL_ADDR     = 8'hf2; // external_trigger_edge
  localparam logic [7:0] PENDING_ADDR      = 8'hf3; // external_pending_flags
  localparam logic [7:0] MASK_ADDR         = 8'hf4; // external_mask_reg
  localparam logic [7:0] PRIORITY_ADDR     = 8'hf5; // external_priority_reg
  localparam logic [7:0] TOP_CFG_ADDR      = 8'hf6; // external_vector_config
  localparam logic [7:0] NESTED_ADDR       = 8'hf7; // nested_hold_levels

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] CENTRAL_CTRL_RST  = 8'h87;
  localparam logic [7:0] EDGE_SEL_RST      = 8'h00;
  localparam logic [7:0] PENDING_RST       = 8'h00;
  localparam logic [7:0] MASK_RST          = 8'h00;
  localparam logic [7:0] PRIORITY_RST      = 8'hff;
  localparam logic [7:0] TOP_CFG_RST       = 8'h06;
  localparam logic [7:0] NESTED_RST        = 8'h00;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int unsigned TIMER_EN_BIT     = 7;  // multifunction_timer_enable
  localparam int unsigned TOP_PEND_BIT     = 6;  // top_pending
  localparam int unsigned TOP_EN_BIT       = 5;  // top_maskable_enable
  localparam int unsigned IEN_BIT          = 4;  // global_irq_enable
  localparam int unsigned MODE_BIT         = 3;  // arbitration_mode_select
  localparam int unsigned CPL_MSB          = 2;  // current_priority_level
  localparam int unsigned TOP_EDGE_BIT     = 3;  // top_edge_select
  localparam int unsigned TOP_SRC_BIT      = 2;  // top_source_select
  localparam int unsigned VEC_MSB          = 7;  // vector high nibble
  localparam int unsigned VEC_LSB          = 4;
  localparam int unsigned NOT_MASKABLE_BIT = 7;  // top_not_maskable
  localparam int unsigned HOLD_MSB         = 6;  // hold levels 6..0

  // ------------------------------------------------------------------
  // timing counts in core clock cycles
  // ------------------------------------------------------------------
  localparam logic [2:0] ARB_CYCLES        = 3'h5;
  localparam logic [2:0] SAMPLE_SLOT       = 3'h4;
  localparam logic [4:0] ENTRY_BASE        = 5'h12; // 18 cycles
  localparam logic [4:0] ENTRY_STACK_RF    = 5'h02;
  localparam logic [4:0] ENTRY_SEG_PUSH    = 5'h02;
  localparam logic [4:0] ENTRY_WAKE        = 5'h01;
  localparam logic [2:0] LEVEL_LOWEST      = 3'h7;
  // vector handed out for the top-level channel; value is arbitrary
  localparam logic [7:0] TOP_VECTOR        = 8'h00;

  // ------------------------------------------------------------------
  // carrier types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       wr;     // write strobe
    logic       rd;     // read strobe
    logic [7:0] addr;   // register offset
    logic [7:0] wdata;  // write data
  } reg_bus_t;

  typedef struct packed {
    logic iret;         // return from routine, one-cycle pulse
    logic ei;           // enable-interrupts instruction
    logic di;           // disable-interrupts instruction
    logic wrote;        // current instruction has performed a write
    logic instr_end;    // current instruction completes this cycle
    logic wfi;          // core sits in wait-for-interrupt
    logic stack_rf;     // system stack lives in the register file
    logic seg_push;     // segment_push_enable
  } cpu_in_t;

  typedef struct packed {
    logic       top;    // top-level request pending service
    logic       irq;    // channel request pending service
    logic [2:0] level;  // level of the request
    logic [7:0] vector; // vector table entry
  } cpu_req_t;

endpackage

//--- rtl/intc_top.sv
// top-level and external channel interrupt controller with register port
`timescale 1ns/100ps
// Behaviour
// - top source: pin when select 1, watchdog 0
// - pin edge: rising when set, falling cleared
// - top event sets pending; ack clears
// - maskable top needs enable, global, pending
// - not-maskable bit set-only, bypasses global enable
// - top routine never preempted by anything
// - top entry/return leave enable, level alone
// - channel pending set by hardware, software
// - channel request needs mask, pending, enable
// - 3-bit level, 7 never acknowledged; vector
// - sample every 5 cycles; ack one more
// - abort without write, else wait completion
// - channel latency 26 to 55 cycles
// - top latency 22 to 51 cycles
// - entry 18, +2 stack, +2 segment, +1 wake
// - channel entry clears enable, channel return/ei sets it
// - mode bit: 0 concurrent, 1 nested
// - current level writable, nested hardware updates
// - control bit 7 enables multifunction timer
// - eight edge bits, 1 rising 0 falling
// - external pending set on edge, ack clears
// - external mask 0 blocks the channel
// - pair priority plus fixed channel lsb
module intc_top (
  // clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_nrst,
  // register port
  input  wire intc_pkg::reg_bus_t i_bus,
  output logic [7:0]              o_rdata,
  // event sources
  input  wire logic [7:0]         i_ext_pin,
  input  wire logic               i_nmi_pin,
  input  wire logic               i_wdg_eoc,
  // core sequencer
  input  wire intc_pkg::cpu_in_t  i_cpu,
  output intc_pkg::cpu_req_t      o_req,
  output logic                    o_abort,
  output logic                    o_take,
  output logic [4:0]              o_entry_cycles,
  // peripheral control
  output logic                    o_timer_enable
);
  import intc_pkg::*;

  // ------------------------------------------------------------------
  // state and declarations
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {ST_ARB, ST_REQ, ST_ACK} arb_st_t;
  logic [7:0] central_q, central_d;   // central_interrupt_control
  logic [7:0] edge_q,    edge_d;      // external_trigger_edge
  logic [7:0] pend_q,    pend_d;      // external_pending_flags
  logic [7:0] mask_q,    mask_d;      // external_mask_reg
  logic [7:0] prio_q,    prio_d;      // external_priority_reg
  logic [7:0] topcfg_q,  topcfg_d;    // external_vector_config
  logic [7:0] nested_q,  nested_d;    // nested_hold_levels
  logic       top_act_q, top_act_d;   // top routine is running
  logic [2:0] cnt_q,     cnt_d;       // arbitration slot counter
  arb_st_t    st_q,      st_d;        // arbitration state
  logic [2:0] win_q,     win_d;       // channel that won
  cpu_req_t   req_q,     req_d;       // request to the core
  logic       take_q,    take_d;      // entry cycle granted
  logic       abort_q,   abort_d;     // abort current instruction
  logic [7:0] rdata_q,   rdata_d;     // read answer
  logic [4:0] entry_q,   entry_d;     // entry cycle length
  // pin synchronisers; stage one feeds stage two only
  logic [7:0] ext_s1_q, ext_s2_q, ext_prev_q;
  logic       nmi_s1_q, nmi_s2_q, nmi_prev_q;
  logic [7:0] ext_evt;                // edge seen on a channel
  logic       top_evt;                // selected top-level event
  logic [7:0] cand;                   // channels allowed to request
  logic       top_cand;               // top-level allowed to request
  logic       go;                     // entry cycle starts now
  // level of channel idx from its pair field plus fixed lsb
  function automatic logic [2:0] chan_level(input logic [7:0] plr, input int idx);
    chan_level = {plr[(idx / 2) * 2 + 1], plr[(idx / 2) * 2], idx[0]};
  endfunction

  // ------------------------------------------------------------------
  // edge detection
  // ------------------------------------------------------------------
  // inputs sit behind two flops, so a source must hold each level a full clock
  for (genvar g = 0; g < 8; g++) begin : g_edge
    // rising when the edge bit is set, falling otherwise
    assign ext_evt[g] = edge_q[g] ? (ext_s2_q[g] & ~ext_prev_q[g])
                                  : (~ext_s2_q[g] & ext_prev_q[g]);
  end
  // top source mux: pin edge or watchdog end of count
  always_comb begin
    if (topcfg_q[TOP_SRC_BIT]) begin
      top_evt = topcfg_q[TOP_EDGE_BIT] ? (nmi_s2_q & ~nmi_prev_q)
                                       : (~nmi_s2_q & nmi_prev_q);
    end else begin
      top_evt = i_wdg_eoc;
    end
  end

  // ------------------------------------------------------------------
  // request qualification
  // ------------------------------------------------------------------
  always_comb begin
    cand = pend_q & mask_q & {8{central_q[IEN_BIT]}};
    top_cand = central_q[TOP_PEND_BIT] &
               (nested_q[NOT_MASKABLE_BIT] |
                (central_q[TOP_EN_BIT] & central_q[IEN_BIT]));
    // abort right away unless a write already happened
    go = (st_q == ST_REQ) & (~i_cpu.wrote | i_cpu.instr_end);
  end

  // ------------------------------------------------------------------
  // next state of registers and arbitration
  // ------------------------------------------------------------------
  always_comb begin
    logic [2:0] best;
    logic [2:0] best_ch;
    logic       found;
    logic [2:0] pop;
    logic       popped;
    best    = central_q[CPL_MSB:0];
    best_ch = 3'h0;
    found   = 1'b0;
    pop     = LEVEL_LOWEST;
    popped  = 1'b0;
    central_d = central_q;
    edge_d    = edge_q;
    pend_d    = pend_q;
    mask_d    = mask_q;
    prio_d    = prio_q;
    topcfg_d  = topcfg_q;
    nested_d  = nested_q;
    top_act_d = top_act_q;
    st_d      = st_q;
    win_d     = win_q;
    req_d     = req_q;
    take_d    = 1'b0;
    abort_d   = 1'b0;
    rdata_d   = 8'h00;
    // arbitration runs on its own, regardless of instruction flow
    cnt_d = (cnt_q == ARB_CYCLES - 3'h1) ? 3'h0 : cnt_q + 3'h1;
    // software writes
    if (i_bus.wr) begin
      unique case (i_bus.addr)
        CENTRAL_CTRL_ADDR: central_d = i_bus.wdata;
        EDGE_SEL_ADDR:     edge_d    = i_bus.wdata;
        PENDING_ADDR:      pend_d    = i_bus.wdata;
        MASK_ADDR:         mask_d    = i_bus.wdata;
        PRIORITY_ADDR:     prio_d    = i_bus.wdata;
        TOP_CFG_ADDR:      topcfg_d  = i_bus.wdata;
        // not-maskable bit can only be set; hold levels are writable
        NESTED_ADDR: begin
          nested_d = {nested_q[NOT_MASKABLE_BIT] | i_bus.wdata[NOT_MASKABLE_BIT],
                      i_bus.wdata[HOLD_MSB:0]};
        end
        default: ;
      endcase
    end
    // read answer, valid the cycle after the strobe only
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        CENTRAL_CTRL_ADDR: rdata_d = central_q;
        EDGE_SEL_ADDR:     rdata_d = edge_q;
        PENDING_ADDR:      rdata_d = pend_q;
        MASK_ADDR:         rdata_d = mask_q;
        PRIORITY_ADDR:     rdata_d = prio_q;
        TOP_CFG_ADDR:      rdata_d = topcfg_q;
        NESTED_ADDR:       rdata_d = nested_q;
        default:           rdata_d = 8'h00;
      endcase
    end
    // enable instructions
    if (i_cpu.ei) begin
      central_d[IEN_BIT] = 1'b1;
    end else if (i_cpu.di) begin
      central_d[IEN_BIT] = 1'b0;
    end
    // return from a routine
    if (i_cpu.iret) begin
      if (top_act_q) begin
        top_act_d = 1'b0;
      end else begin
        central_d[IEN_BIT] = 1'b1;
        if (central_q[MODE_BIT]) begin
          // pop the most urgent held level back into the current level
          for (int i = HOLD_MSB; i >= 0; i--) begin
            if (nested_q[i]) begin
              pop    = 3'(i);
              popped = 1'b1;
            end
          end
          central_d[CPL_MSB:0] = pop;
          if (popped) begin
            nested_d[pop] = 1'b0;
          end
        end
      end
    end
    // pick the most urgent channel, strictly above the current level
    for (int i = 0; i < 8; i++) begin
      if (cand[i] && (chan_level(prio_q, i) < best)) begin
        best    = chan_level(prio_q, i);
        best_ch = 3'(i);
        found   = 1'b1;
      end
    end
    unique case (st_q)
      // sample only on the slot; a running top routine blocks all
      ST_ARB: begin
        if ((cnt_q == SAMPLE_SLOT) && !top_act_q) begin
          if (top_cand) begin
            req_d = '{top: 1'b1, irq: 1'b0, level: 3'h0, vector: TOP_VECTOR};
            st_d  = ST_REQ;
          end else if (found) begin
            req_d = '{top: 1'b0, irq: 1'b1, level: best,
                      vector: {topcfg_q[VEC_MSB:VEC_LSB], best_ch, 1'b0}};
            win_d = best_ch;
            st_d  = ST_REQ;
          end
        end
      end
      // wait for a safe point in the current instruction
      ST_REQ: begin
        if (go) begin
          abort_d = ~i_cpu.wrote;
          take_d  = 1'b1;
          st_d    = ST_ACK;
          req_d   = '0;
          if (req_q.top) begin
            // top entry keeps the enable, level and hold bits
            top_act_d                = 1'b1;
            central_d[TOP_PEND_BIT]  = 1'b0;
          end else begin
            central_d[IEN_BIT] = 1'b0;
            pend_d[win_q]      = 1'b0;
            if (central_q[MODE_BIT] && (central_q[CPL_MSB:0] != LEVEL_LOWEST)) begin
              nested_d[central_q[CPL_MSB:0]] = 1'b1;
            end
            if (central_q[MODE_BIT]) begin
              central_d[CPL_MSB:0] = req_q.level;
            end
          end
        end
      end
      // the extra acknowledge cycle
      ST_ACK: st_d = ST_ARB;
      default: st_d = ST_ARB;
    endcase
    // hardware sets come last so a clear in the same cycle loses
    pend_d = pend_d | ext_evt;
    if (top_evt) begin
      central_d[TOP_PEND_BIT] = 1'b1;
    end
    // entry cycle length for the next service
    entry_d = ENTRY_BASE
            + (i_cpu.stack_rf ? ENTRY_STACK_RF : 5'h00)
            + (i_cpu.seg_push ? ENTRY_SEG_PUSH : 5'h00)
            + (i_cpu.wfi ? ENTRY_WAKE : 5'h00);
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  // synchronous reset of all control state
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      central_q  <= CENTRAL_CTRL_RST;
      edge_q     <= EDGE_SEL_RST;
      pend_q     <= PENDING_RST;
      mask_q     <= MASK_RST;
      prio_q     <= PRIORITY_RST;
      topcfg_q   <= TOP_CFG_RST;
      nested_q   <= NESTED_RST;
      top_act_q  <= 1'b0;
      cnt_q      <= 3'h0;
      st_q       <= ST_ARB;
      win_q      <= 3'h0;
      req_q      <= '0;
      take_q     <= 1'b0;
      abort_q    <= 1'b0;
      rdata_q    <= 8'h00;
      entry_q    <= ENTRY_BASE;
    end else begin
      central_q  <= central_d;
      edge_q     <= edge_d;
      pend_q     <= pend_d;
      mask_q     <= mask_d;
      prio_q     <= prio_d;
      topcfg_q   <= topcfg_d;
      nested_q   <= nested_d;
      top_act_q  <= top_act_d;
      cnt_q      <= cnt_d;
      st_q       <= st_d;
      win_q      <= win_d;
      req_q      <= req_d;
      take_q     <= take_d;
      abort_q    <= abort_d;
      rdata_q    <= rdata_d;
      entry_q    <= entry_d;
    end
  end

  // synchronisers run through reset, so no false edge appears when it lifts
  always_ff @(posedge i_clk) begin
    ext_s1_q   <= i_ext_pin;
    ext_s2_q   <= ext_s1_q;
    ext_prev_q <= ext_s2_q;
    nmi_s1_q   <= i_nmi_pin;
    nmi_s2_q   <= nmi_s1_q;
    nmi_prev_q <= nmi_s2_q;
  end

  // outputs straight from flops
  assign o_rdata        = rdata_q;
  assign o_req          = req_q;
  assign o_abort        = abort_q;
  assign o_take         = take_q;
  assign o_entry_cycles = entry_q;
  assign o_timer_enable = central_q[TIMER_EN_BIT];

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  property p_pend_set_wins;
    @(posedge i_clk) disable iff (!i_nrst)
      (ext_evt != 8'h00) |=> ((pend_q & $past(ext_evt)) == $past(ext_evt));
  endproperty
  a_pend_set_wins: assert property (p_pend_set_wins)
    else $error("edge event lost from pending flags");
  property p_sample_slot;
    @(posedge i_clk) disable iff (!i_nrst)
      $rose(o_req.irq) || $rose(o_req.top) |-> $past(cnt_q) == SAMPLE_SLOT;
  endproperty
  a_sample_slot: assert property (p_sample_slot)
    else $error("request raised outside the sampling slot");
  property p_irq_needs_enable;
    @(posedge i_clk) disable iff (!i_nrst)
      $rose(o_req.irq) |-> $past(central_q[IEN_BIT]) && $past(cand != 8'h00);
  endproperty
  a_irq_needs_enable: assert property (p_irq_needs_enable)
    else $error("channel request without mask, pending and enable");
  property p_never_level7;
    @(posedge i_clk) disable iff (!i_nrst)
      o_req.irq |-> o_req.level != LEVEL_LOWEST;
  endproperty
  a_never_level7: assert property (p_never_level7)
    else $error("lowest level request raised");
  property p_top_qualified;
    @(posedge i_clk) disable iff (!i_nrst)
      $rose(o_req.top) |-> $past(central_q[TOP_PEND_BIT]) &&
        ($past(nested_q[NOT_MASKABLE_BIT]) ||
         ($past(central_q[TOP_EN_BIT]) && $past(central_q[IEN_BIT])));
  endproperty
  a_top_qualified: assert property (p_top_qualified)
    else $error("top request raised while masked");
  property p_no_preempt;
    @(posedge i_clk) disable iff (!i_nrst)
      top_act_q |-> !o_req.irq && !o_req.top;
  endproperty
  a_no_preempt: assert property (p_no_preempt)
    else $error("request raised during top routine");
  property p_top_keeps_enable;
    @(posedge i_clk) disable iff (!i_nrst)
      take_q && top_act_q && !$past(i_bus.wr) && !$past(i_cpu.ei) && !$past(i_cpu.di) |->
        central_q[IEN_BIT] == $past(central_q[IEN_BIT]) &&
        central_q[CPL_MSB:0] == $past(central_q[CPL_MSB:0]);
  endproperty
  a_top_keeps_enable: assert property (p_top_keeps_enable)
    else $error("top entry changed enable or level");
  property p_entry_clears_enable;
    @(posedge i_clk) disable iff (!i_nrst)
      take_q && !top_act_q |-> !central_q[IEN_BIT] ##1 (st_q == ST_ARB);
  endproperty
  a_entry_clears_enable: assert property (p_entry_clears_enable)
    else $error("channel entry left global enable set");
  property p_abort_safe;
    @(posedge i_clk) disable iff (!i_nrst)
      o_abort |-> o_take && !$past(i_cpu.wrote);
  endproperty
  a_abort_safe: assert property (p_abort_safe)
    else $error("abort after a write");
  property p_entry_len;
    @(posedge i_clk) disable iff (!i_nrst)
      i_cpu.stack_rf && i_cpu.seg_push && i_cpu.wfi |=> o_entry_cycles == 5'h17;
  endproperty
  a_entry_len: assert property (p_entry_len)
    else $error("entry cycle length wrong");
  property p_not_maskable_sticky;
    @(posedge i_clk) disable iff (!i_nrst)
      nested_q[NOT_MASKABLE_BIT] |=> nested_q[NOT_MASKABLE_BIT];
  endproperty
  a_not_maskable_sticky: assert property (p_not_maskable_sticky)
    else $error("not-maskable bit cleared without reset");

endmodule

//--- sim/core_model.sv
// core sequencer stand-in that drives instruction status
`timescale 1ns/100ps
module core_model (
  // clock and bench control
  input  wire logic         i_clk,
  input  wire logic         i_slow,
  input  wire logic         i_ret,
  // status towards the controller
  output intc_pkg::cpu_in_t o_cpu
);
  import intc_pkg::*;
  // ----------------------------------------------------------------
  // four-cycle instructions
  // ----------------------------------------------------------------
  logic [1:0] step_q = 2'h0; // position inside the instruction
  // free-running, so a slow core finishes at an arbitrary phase
  always @(posedge i_clk) begin
    step_q <= step_q + 2'h1;
  end
  // a slow core has already written, so it cannot be aborted; it also
  // wakes from wait-for-interrupt, giving the longest entry cycle
  assign o_cpu = {i_ret, 2'h0, i_slow, step_q == 2'h3, i_slow, i_slow, i_slow};
endmodule

//--- sim/intc_top_test.sv
// self-checking bench for the interrupt control block
`timescale 1ns/100ps
module intc_top_test;
  import intc_pkg::*;
  logic        clk, nrst, nmi, wdg, slow, ret, abort, take, ten, rd_d;
  logic [7:0]  pins, rdata;
  logic [4:0]  ent;
  logic [15:0] seed;
  reg_bus_t    bus;
  cpu_in_t     cpu;
  cpu_req_t    req, lr;  // lr keeps the request seen before entry
  int          miscompares, total_checks;
  logic [7:0]  rq[$];    // expected read data
  logic [18:0] tq[$];    // expected abort, entry length, request
  intc_top dut (.i_clk(clk), .i_nrst(nrst), .i_bus(bus), .o_rdata(rdata),
    .i_ext_pin(pins), .i_nmi_pin(nmi), .i_wdg_eoc(wdg), .i_cpu(cpu), .o_req(req),
    .o_abort(abort), .o_take(take), .o_entry_cycles(ent), .o_timer_enable(ten));
  core_model cm (.i_clk(clk), .i_slow(slow), .i_ret(ret), .o_cpu(cpu));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string n, input logic [18:0] s, input logic [18:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) bus <= {2'b10, a, d};
    @(posedge clk) bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(posedge clk) bus <= {2'b01, a, 8'h00};
    @(posedge clk) bus.rd <= 1'b0;
  endtask
  // waits under a bound for the entry grant
  task automatic await(input logic [18:0] e);
    int i;
    i = 0;
    tq.push_back(e);
    while (take !== 1'b1 && i < 200) begin
      @(negedge clk);
      i++;
    end
    if (i == 200) miscompares++;
    @(posedge clk);
  endtask
  task automatic leave;
    ret <= 1'b1;
    @(posedge clk) ret <= 1'b0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog and result watcher
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // bound well above the expected run of about 160 cycles
  initial begin
    #200000;
    miscompares++;
    report_and_stop;
  end
  // read data stand one cycle only, so they are judged in that cycle
  always @(posedge clk) begin
    if (rd_d) chk("rdata", rdata, rq.pop_front());
    if (take) chk("entry", {abort, ent, lr}, (tq.size() > 0) ? tq.pop_front() : 19'h0);
    rd_d <= bus.rd;
    if (req.irq | req.top) lr <= req;
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0; bus = '0; pins = 8'h00; nmi = 1'b1; wdg = 1'b0; slow = 1'b0;
    ret = 1'b0; seed = 16'h4814; miscompares = 0; total_checks = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rd(CENTRAL_CTRL_ADDR, 8'h87);
    seed = lfsr(seed);
    wr(EDGE_SEL_ADDR, seed[7:0]);
    rd(EDGE_SEL_ADDR, seed[7:0]);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    rd(PENDING_ADDR, 8'h00);
    wr(CENTRAL_CTRL_ADDR, 8'h07);
    repeat (2) @(negedge clk);
    chk("timer", ten, 1'b0);
    $display("test registers done");
    wr(MASK_ADDR, 8'h01);
    wr(PRIORITY_ADDR, 8'h00);
    wr(EDGE_SEL_ADDR, 8'h01);
    wr(CENTRAL_CTRL_ADDR, 8'h97);
    pins[0] <= 1'b1;
    await({1'b1, ENTRY_BASE, 2'b01, 3'h0, 8'h00});
    rd(CENTRAL_CTRL_ADDR, 8'h87);
    rd(PENDING_ADDR, 8'h00);
    leave;
    rd(CENTRAL_CTRL_ADDR, 8'h97);
    wr(PENDING_ADDR, 8'h02);
    repeat (12) @(negedge clk);
    chk("masked", req, 13'h0);
    @(posedge clk) slow <= 1'b1;
    wr(MASK_ADDR, 8'h02);
    await({1'b0, 5'(ENTRY_BASE + ENTRY_STACK_RF + ENTRY_SEG_PUSH + ENTRY_WAKE), 2'b01, 3'h1,
           8'h02});
    leave;
    slow <= 1'b0;
    // nested mode loads the winner's level into the current level
    wr(CENTRAL_CTRL_ADDR, 8'h9f);
    wr(PENDING_ADDR, 8'h02);
    await({1'b1, ENTRY_BASE, 2'b01, 3'h1, 8'h02});
    rd(CENTRAL_CTRL_ADDR, 8'h89);
    leave;
    rd(CENTRAL_CTRL_ADDR, 8'h9f);
    $display("test channels done");
    wr(NESTED_ADDR, 8'h80);
    wr(CENTRAL_CTRL_ADDR, 8'h87);
    nmi <= 1'b0;
    await({1'b1, ENTRY_BASE, 2'b10, 3'h0, TOP_VECTOR});
    rd(CENTRAL_CTRL_ADDR, 8'h87);
    // a software top request inside the routine must wait for its return
    wr(CENTRAL_CTRL_ADDR, 8'hc7);
    repeat (12) @(negedge clk);
    chk("no preempt", req, 13'h0);
    @(posedge clk) leave;
    await({1'b1, ENTRY_BASE, 2'b10, 3'h0, TOP_VECTOR});
    leave;
    rd(CENTRAL_CTRL_ADDR, 8'h87);
    wr(TOP_CFG_ADDR, 8'h02);
    nmi <= 1'b1;
    repeat (8) @(posedge clk);
    nmi <= 1'b0;
    repeat (12) @(negedge clk);
    chk("pin ignored", req, 13'h0);
    @(posedge clk) wdg <= 1'b1;
    @(posedge clk) wdg <= 1'b0;
    await({1'b1, ENTRY_BASE, 2'b10, 3'h0, TOP_VECTOR});
    leave;
    // rising edge selected on the top pin
    wr(TOP_CFG_ADDR, 8'h0e);
    nmi <= 1'b1;
    await({1'b1, ENTRY_BASE, 2'b10, 3'h0, TOP_VECTOR});
    leave;
    $display("test top level done");
    report_and_stop;
  end
endmodule
